// File: shared/mic_pkg.sv
// constants, types and register map of the interrupt controller
//
// Contract
// - thirteen external sources: five request, eight wakeup
// - assigned wakeup pin edge sets its flag
// - wakeup group enable zero suppresses all wakeups
// - all wakeup sources share vector nine
// - per-pin bit selects rising or falling edge
// - assigned request pin edge sets its flag
// - per-pin enable bit gates request pin recognition
// - request pins use vectors eight down to four
// - request pin zero highest, pin four lowest
// - global mask bit one blocks every request
// - exception entry sets the global mask bit
// - 23 internal sources, vectors twenty to eleven
// - internal request latched only while enabled
// - highest priority chosen, others stay pending
// - masked request held pending, never discarded
// - entry after instruction end, stack pc, ccr
// - vector address of accepted request is produced
// - clear colliding with request: exception still taken
// - entry takes wait plus fourteen fixed states
// - ccr stacked as word, even byte restored
// - pin function switch with low pin sets flag, request pins only when falling edge selected
// - flag clear right after function write ignored
// - flags cleared only by writing zero
// - wakeup edge bit zero falling, one rising
package mic_pkg;

  // source counts
  localparam int NUM_REQ_PINS = 5;
  localparam int NUM_WAKE_PINS = 8;
  localparam int NUM_INT_SRC = 23;
  localparam int NUM_PEND = NUM_REQ_PINS + 1 + NUM_INT_SRC;
  localparam int WAKE_PEND_IDX = NUM_REQ_PINS;

  // register byte offsets
  localparam logic [7:0] OFS_ENABLE_ONE = 8'h00;
  localparam logic [7:0] OFS_ENABLE_TWO = 8'h04;
  localparam logic [7:0] OFS_FLAGS_ONE = 8'h08;
  localparam logic [7:0] OFS_FLAGS_TWO = 8'h0c;
  localparam logic [7:0] OFS_WAKE_FLAGS = 8'h10;
  localparam logic [7:0] OFS_EDGE_SEL = 8'h14;
  localparam logic [7:0] OFS_WAKE_EDGE = 8'h18;
  localparam logic [7:0] OFS_PFR_ONE = 8'h1c;
  localparam logic [7:0] OFS_PFR_THREE = 8'h20;
  localparam logic [7:0] OFS_PFR_FIVE = 8'h24;
  localparam logic [7:0] OFS_CCR = 8'h28;
  localparam logic [7:0] OFS_FLAGS_EXT = 8'h2c;
  localparam logic [7:0] OFS_ENABLE_EXT = 8'h30;

  // field positions and widths
  localparam int EN1_WAKE_BIT = 5;
  localparam int INT_R1_LSB = 6;
  localparam int INT_R1_N = 2;
  localparam int INT_R2_N = 8;
  localparam int INT_EXT_N = 13;
  localparam int PFR_ONE_REQ_LSB = 1;
  localparam int PFR_THREE_REQ_BIT = 0;
  localparam int CCR_MASK_BIT = 7;

  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CCR_RST = 8'h80;
  localparam logic [4:0] REQ_LEVEL_RST = 5'h1f;
  localparam logic [7:0] WAKE_LEVEL_RST = 8'hff;

  // vector numbers
  localparam logic [4:0] VEC_REQ_BASE = 5'h04;
  localparam logic [4:0] VEC_WAKE = 5'h09;
  localparam int VEC_INT_FIRST = 11;
  localparam int VEC_INT_LAST = 20;
  localparam int VEC_ADDR_SHIFT = 1;

  // exception entry timing in states (one state is one clock)
  localparam logic [2:0] STACK_STATES = 3'h4;
  localparam logic [2:0] VECTOR_STATES = 3'h2;
  localparam logic [2:0] FETCH_STATES = 3'h4;
  localparam logic [2:0] INTERNAL_STATES = 3'h4;
  localparam logic [2:0] PC_PUSH_STEP = 3'h0;
  localparam logic [2:0] CCR_PUSH_STEP = 3'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_STACK, ST_VECTOR, ST_FETCH, ST_INTERNAL}
    mic_state_type;

  // signals toward the cpu during exception entry
  typedef struct packed {
    logic busy;
    logic push;
    logic [15:0] word;
    logic vfetch;
    logic [15:0] vaddr;
    logic start;
  } mic_entry_type;

endpackage

// File: verilog/mic_interrupt_controller.sv
// interrupt controller: pin edge capture, flags, priority and exception entry
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps

module mic_interrupt_controller
  import mic_pkg::*;
(
  input wire logic clock_i, // 125 MHz system clock
  input wire logic rstn_i, // asynchronous reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic [NUM_REQ_PINS-1:0] req_pins_i, // request pin levels
  input wire logic [NUM_WAKE_PINS-1:0] wakeup_pins_i, // wakeup pin levels
  input wire logic [NUM_INT_SRC-1:0] internal_req_i, // peripheral request pulses
  input wire logic instr_done_i, // cpu finishes current instruction
  input wire logic [15:0] next_pc_i, // address of the next instruction
  input wire logic rte_i, // return_from_exception ccr restore strobe
  input wire logic [15:0] rte_ccr_word_i, // ccr word popped from stack
  output logic mask_o, // global mask bit of the ccr
  output mic_entry_type entry_o // exception entry signals
);

  // ==========================================================================
  // functions
  // ==========================================================================

  // word address compare against a byte offset
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    reg_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // lowest set index of the pending vector, which is the highest priority
  function automatic logic [4:0] first_idx(input logic [NUM_PEND-1:0] v);
    first_idx = 5'h00;
    for (int i = NUM_PEND - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        first_idx = 5'(i);
      end
    end
  endfunction

  // vector number of a pending index
  function automatic logic [4:0] vec_of(input logic [4:0] idx);
    int k;
    k = 0;
    if (int'(idx) < NUM_REQ_PINS)
    begin
      vec_of = VEC_REQ_BASE + idx;
    end
    else if (int'(idx) == WAKE_PEND_IDX)
    begin
      vec_of = VEC_WAKE;
    end
    else
    begin
      k = int'(idx) - WAKE_PEND_IDX - 1;
      vec_of = 5'(VEC_INT_FIRST + (k * (VEC_INT_LAST - VEC_INT_FIRST)) / (NUM_INT_SRC - 1));
    end
  endfunction

  // ==========================================================================
  // state
  // ==========================================================================

  logic [NUM_REQ_PINS-1:0] pin_en_q;
  logic wake_en_q;
  logic [NUM_INT_SRC-1:0] int_en_q;
  logic [NUM_REQ_PINS-1:0] pin_flag_q, pin_flag_d;
  logic [NUM_WAKE_PINS-1:0] wake_flag_q, wake_flag_d;
  logic [NUM_INT_SRC-1:0] int_flag_q, int_flag_d;
  logic [NUM_REQ_PINS-1:0] edge_q;
  logic [NUM_WAKE_PINS-1:0] wake_edge_q;
  logic [7:0] pfr1_q, pfr3_q, pfr5_q;
  logic [7:0] ccr_q, ccr_d, ccr_save_q;
  logic last_pfr_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [NUM_REQ_PINS-1:0] req_prev_q;
  logic [NUM_WAKE_PINS-1:0] wake_pin_prev_q, wake_func_prev_q;
  mic_state_type state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [4:0] vec_q, vec_d;
  mic_entry_type entry_q, entry_d;

  // ==========================================================================
  // wishbone decode
  // ==========================================================================

  wire bus_req = wb_cyc_i & wb_stb_i;
  wire acc_done = bus_req & ack_q;
  wire wr_fire = acc_done & wb_we_i & wb_sel_i[0];
  wire hit_en1 = reg_hit(wb_adr_i, OFS_ENABLE_ONE);
  wire hit_en2 = reg_hit(wb_adr_i, OFS_ENABLE_TWO);
  wire hit_rf1 = reg_hit(wb_adr_i, OFS_FLAGS_ONE);
  wire hit_rf2 = reg_hit(wb_adr_i, OFS_FLAGS_TWO);
  wire hit_wf = reg_hit(wb_adr_i, OFS_WAKE_FLAGS);
  wire hit_edge = reg_hit(wb_adr_i, OFS_EDGE_SEL);
  wire hit_wedge = reg_hit(wb_adr_i, OFS_WAKE_EDGE);
  wire hit_pfr1 = reg_hit(wb_adr_i, OFS_PFR_ONE);
  wire hit_pfr3 = reg_hit(wb_adr_i, OFS_PFR_THREE);
  wire hit_pfr5 = reg_hit(wb_adr_i, OFS_PFR_FIVE);
  wire hit_ccr = reg_hit(wb_adr_i, OFS_CCR);
  wire hit_rfx = reg_hit(wb_adr_i, OFS_FLAGS_EXT);
  wire hit_enx = reg_hit(wb_adr_i, OFS_ENABLE_EXT);
  wire hit_pfr = hit_pfr1 | hit_pfr3 | hit_pfr5;

  // flag clears are dropped in the access right after a function write
  wire clr_ok = wr_fire & ~last_pfr_q;

  // read data mux, unmapped words read as zero
  wire [31:0] rd_word =
    hit_en1 ? {24'h0, int_en_q[INT_R1_N-1:0], wake_en_q, pin_en_q} :
    hit_en2 ? {24'h0, int_en_q[INT_R1_N +: INT_R2_N]} :
    hit_rf1 ? {24'h0, int_flag_q[INT_R1_N-1:0], 1'b0, pin_flag_q} :
    hit_rf2 ? {24'h0, int_flag_q[INT_R1_N +: INT_R2_N]} :
    hit_wf ? {24'h0, wake_flag_q} :
    hit_edge ? {27'h0, edge_q} :
    hit_wedge ? {24'h0, wake_edge_q} :
    hit_pfr1 ? {24'h0, pfr1_q} :
    hit_pfr3 ? {24'h0, pfr3_q} :
    hit_pfr5 ? {24'h0, pfr5_q} :
    hit_ccr ? {24'h0, ccr_q} :
    hit_rfx ? {19'h0, int_flag_q[INT_R1_N+INT_R2_N +: INT_EXT_N]} :
    hit_enx ? {19'h0, int_en_q[INT_R1_N+INT_R2_N +: INT_EXT_N]} :
    32'h0000_0000;

  // ==========================================================================
  // pin edge detection
  // ==========================================================================

  // an unassigned request pin looks high, so a function switch with the
  // pin low shows as an edge
  wire [NUM_REQ_PINS-1:0] req_func = {pfr1_q[PFR_ONE_REQ_LSB +: NUM_REQ_PINS-1],
                                      pfr3_q[PFR_THREE_REQ_BIT]};
  wire [NUM_REQ_PINS-1:0] req_eff = req_pins_i | ~req_func;
  wire [NUM_REQ_PINS-1:0] req_rise = ~req_prev_q & req_eff;
  wire [NUM_REQ_PINS-1:0] req_fall = req_prev_q & ~req_eff;
  wire [NUM_REQ_PINS-1:0] req_set = (req_rise & edge_q) | (req_fall & ~edge_q);

  // wakeup edges on assigned pins, plus the spurious set on assignment
  wire [NUM_WAKE_PINS-1:0] wpin_rise = ~wake_pin_prev_q & wakeup_pins_i;
  wire [NUM_WAKE_PINS-1:0] wpin_fall = wake_pin_prev_q & ~wakeup_pins_i;
  wire [NUM_WAKE_PINS-1:0] wake_real = pfr5_q & wake_func_prev_q &
    ((wpin_rise & wake_edge_q) | (wpin_fall & ~wake_edge_q));
  wire [NUM_WAKE_PINS-1:0] wake_spur = pfr5_q & ~wake_func_prev_q & ~wakeup_pins_i;
  wire [NUM_WAKE_PINS-1:0] wake_set = wake_real | wake_spur;

  // internal requests reach the flags only when enabled
  wire [NUM_INT_SRC-1:0] int_set = internal_req_i & int_en_q;

  // ==========================================================================
  // flag update, set wins over a clear in the same cycle
  // ==========================================================================

  wire clr_rf1 = clr_ok & hit_rf1;
  wire clr_rf2 = clr_ok & hit_rf2;
  wire clr_rfx = clr_ok & hit_rfx;
  wire clr_wf = clr_ok & hit_wf;
  wire [NUM_REQ_PINS-1:0] pin_clr = clr_rf1 ? ~wb_dat_i[NUM_REQ_PINS-1:0] : '0;
  wire [NUM_WAKE_PINS-1:0] wake_clr = clr_wf ? ~wb_dat_i[NUM_WAKE_PINS-1:0] : '0;
  wire [NUM_INT_SRC-1:0] int_clr = {
    clr_rfx ? ~wb_dat_i[INT_EXT_N-1:0] : {INT_EXT_N{1'b0}},
    clr_rf2 ? ~wb_dat_i[INT_R2_N-1:0] : {INT_R2_N{1'b0}},
    clr_rf1 ? ~wb_dat_i[INT_R1_LSB +: INT_R1_N] : {INT_R1_N{1'b0}}};

  // writing one keeps a flag, acceptance never clears it
  assign pin_flag_d = (pin_flag_q & ~pin_clr) | req_set;
  assign wake_flag_d = (wake_flag_q & ~wake_clr) | wake_set;
  assign int_flag_d = (int_flag_q & ~int_clr) | int_set;

  // ==========================================================================
  // priority selection
  // ==========================================================================

  wire wake_pend = wake_en_q & (|wake_flag_q);
  wire [NUM_PEND-1:0] pend = {int_flag_q & int_en_q, wake_pend,
                              pin_flag_q & pin_en_q};
  wire [4:0] win_idx = first_idx(pend);
  wire mask_bit = ccr_q[CCR_MASK_BIT];
  wire accept = (state_q == ST_IDLE) & ~mask_bit & (|pend);
  wire enter = (state_q == ST_WAIT) & instr_done_i;

  // ==========================================================================
  // exception entry sequencer
  // ==========================================================================

  wire [2:0] phase_len = (state_q == ST_STACK) ? STACK_STATES :
                         (state_q == ST_VECTOR) ? VECTOR_STATES :
                         (state_q == ST_FETCH) ? FETCH_STATES : INTERNAL_STATES;
  wire phase_last = (cnt_q == phase_len - 3'h1);

  // next state, fixed state counts after the instruction completes
  always_comb
  begin
    state_d = state_q;
    cnt_d = 3'h0;
    vec_d = vec_q;
    case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_d = ST_WAIT;
          vec_d = vec_of(win_idx);
        end
      end
      ST_WAIT:
      begin
        if (instr_done_i)
        begin
          state_d = ST_STACK;
        end
      end
      ST_STACK, ST_VECTOR, ST_FETCH, ST_INTERNAL:
      begin
        if (phase_last)
        begin
          state_d = (state_q == ST_STACK) ? ST_VECTOR :
                    (state_q == ST_VECTOR) ? ST_FETCH :
                    (state_q == ST_FETCH) ? ST_INTERNAL : ST_IDLE;
        end
        else
        begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ccr: entry sets the mask, a return loads the even byte of the word
  assign ccr_d = enter ? (ccr_q | (8'h01 << CCR_MASK_BIT)) :
                 rte_i ? rte_ccr_word_i[15:8] :
                 (wr_fire & hit_ccr) ? wb_dat_i[7:0] : ccr_q;

  // entry outputs aligned with the next state; old ccr stacked as a word
  wire push_step = (cnt_d == PC_PUSH_STEP) | (cnt_d == CCR_PUSH_STEP);
  assign entry_d.busy = (state_d != ST_IDLE);
  assign entry_d.push = (state_d == ST_STACK) & push_step;
  assign entry_d.word = (cnt_d == PC_PUSH_STEP) ? next_pc_i :
                        {ccr_save_q, ccr_save_q};
  assign entry_d.vfetch = (state_d == ST_VECTOR) & (cnt_d == 3'h0);
  assign entry_d.vaddr = 16'(vec_q) << VEC_ADDR_SHIFT;
  assign entry_d.start = (state_q == ST_INTERNAL) & phase_last;

  // ==========================================================================
  // registers
  // ==========================================================================

  // wishbone slave: ack one cycle after the request, one cycle wide
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      last_pfr_q <= 1'b0;
    end
    else
    begin
      ack_q <= bus_req & ~ack_q;
      dat_q <= (bus_req & ~ack_q) ? rd_word : dat_q;
      last_pfr_q <= acc_done ? (wr_fire & hit_pfr) : last_pfr_q;
    end
  end

  // software written configuration
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_en_q <= REG_RST[NUM_REQ_PINS-1:0];
      wake_en_q <= 1'b0;
      int_en_q <= '0;
      edge_q <= REG_RST[NUM_REQ_PINS-1:0];
      wake_edge_q <= REG_RST;
      pfr1_q <= REG_RST;
      pfr3_q <= REG_RST;
      pfr5_q <= REG_RST;
    end
    else
    begin
      if (wr_fire & hit_en1)
      begin
        pin_en_q <= wb_dat_i[NUM_REQ_PINS-1:0];
        wake_en_q <= wb_dat_i[EN1_WAKE_BIT];
        int_en_q[INT_R1_N-1:0] <= wb_dat_i[INT_R1_LSB +: INT_R1_N];
      end
      if (wr_fire & hit_en2)
        int_en_q[INT_R1_N +: INT_R2_N] <= wb_dat_i[INT_R2_N-1:0];
      if (wr_fire & hit_enx)
        int_en_q[INT_R1_N+INT_R2_N +: INT_EXT_N] <= wb_dat_i[INT_EXT_N-1:0];
      if (wr_fire & hit_edge)
        edge_q <= wb_dat_i[NUM_REQ_PINS-1:0];
      if (wr_fire & hit_wedge)
        wake_edge_q <= wb_dat_i[NUM_WAKE_PINS-1:0];
      if (wr_fire & hit_pfr1)
        pfr1_q <= wb_dat_i[7:0];
      if (wr_fire & hit_pfr3)
        pfr3_q <= wb_dat_i[7:0];
      if (wr_fire & hit_pfr5)
        pfr5_q <= wb_dat_i[7:0];
    end
  end

  // flags, pin history, ccr and sequencer
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_flag_q <= '0;
      wake_flag_q <= '0;
      int_flag_q <= '0;
      req_prev_q <= REQ_LEVEL_RST;
      wake_pin_prev_q <= WAKE_LEVEL_RST;
      wake_func_prev_q <= REG_RST;
      ccr_q <= CCR_RST;
      ccr_save_q <= CCR_RST;
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      vec_q <= 5'h00;
      entry_q <= '0;
    end
    else
    begin
      pin_flag_q <= pin_flag_d;
      wake_flag_q <= wake_flag_d;
      int_flag_q <= int_flag_d;
      req_prev_q <= req_eff;
      wake_pin_prev_q <= wakeup_pins_i;
      wake_func_prev_q <= pfr5_q;
      ccr_q <= ccr_d;
      ccr_save_q <= enter ? ccr_q : ccr_save_q;
      state_q <= state_d;
      cnt_q <= cnt_d;
      vec_q <= vec_d;
      entry_q <= entry_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign mask_o = ccr_q[CCR_MASK_BIT];
  assign entry_o = entry_q;

  // ==========================================================================
  // assertions
  // ==========================================================================

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  chk_mask_blocks_accept: assert property (
    (state_q == ST_IDLE) && mask_bit |=> state_q != ST_WAIT)
    else $error("request accepted while masked");
  chk_entry_sets_mask: assert property (
    enter |=> mask_bit && $past(ccr_q) == ccr_save_q)
    else $error("entry did not set mask or save ccr");
  chk_stack_span: assert property (
    $rose(state_q == ST_STACK) |-> (state_q == ST_STACK)[*4] ##1 (state_q == ST_VECTOR))
    else $error("stacking phase not four states");
  chk_entry_latency: assert property (
    enter |-> ##15 entry_q.start)
    else $error("handler start not fifteen states after entry");
  chk_wake_vector: assert property (
    accept && win_idx == 5'(WAKE_PEND_IDX) |=> vec_q == VEC_WAKE)
    else $error("wakeup request not on shared vector");
  chk_pin_priority: assert property (
    accept && pin_flag_q[0] && pin_en_q[0] |=> vec_q == VEC_REQ_BASE)
    else $error("pin zero did not win priority");
  chk_flag_sticky: assert property (
    pin_flag_q[0] && !(wr_fire && hit_rf1) |=> pin_flag_q[0])
    else $error("pin flag lost without a clear");
  chk_clear_blocked: assert property (
    last_pfr_q && wr_fire && hit_rf1 |=> (pin_flag_q & $past(pin_flag_q)) == $past(pin_flag_q))
    else $error("clear right after function write took effect");
  chk_wake_gate: assert property (
    (state_q == ST_IDLE) && !wake_en_q && !(|(pin_flag_q & pin_en_q)) &&
    !(|(int_flag_q & int_en_q)) |=> state_q != ST_WAIT)
    else $error("wakeup accepted while group disabled");
  chk_ccr_restore: assert property (
    rte_i && !enter |=> ccr_q == $past(rte_ccr_word_i[15:8]))
    else $error("ccr not restored from even byte");
  chk_push_word: assert property (
    enter |=> entry_q.push && entry_q.word == $past(next_pc_i) ##2 entry_q.push)
    else $error("pc and ccr pushes out of place");

endmodule

// File: verification/mic_cpu_model.sv
// cpu model: answers exception entry at an instruction boundary and logs the entry
`timescale 1ns/1ps

module mic_cpu_model
  import mic_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic rstn_i, // reset, active low
  input wire logic [3:0] wait_i, // cycles until the running instruction ends
  input wire mic_entry_type entry_i, // entry signals from the controller
  output logic instr_done_o, // instruction boundary pulse
  output logic [15:0] pc_word_o, // first stacked word
  output logic [15:0] ccr_word_o, // second stacked word
  output logic [15:0] vaddr_o, // vector address seen at fetch
  output int lat_o, // cycles from boundary to handler start
  output int starts_o // handler starts seen
);
  logic taken_q;
  logic second_q;
  int cnt_q;
  int lat_q;

  // ====
  // boundary pulse once per entry, then log stack words, vector and timing
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      instr_done_o <= 1'b0;
      {taken_q, second_q, pc_word_o, ccr_word_o, vaddr_o} <= '0;
      {cnt_q, lat_q, lat_o, starts_o} <= '0;
    end
    else
    begin
      instr_done_o <= 1'b0;
      lat_q <= lat_q + 1;
      if (entry_i.busy && !taken_q)
      begin
        cnt_q <= cnt_q + 1;
        if (cnt_q >= int'(wait_i))
        begin
          instr_done_o <= 1'b1;
          taken_q <= 1'b1;
          lat_q <= 0;
        end
      end
      if (entry_i.push)
      begin
        if (!second_q) pc_word_o <= entry_i.word;
        else ccr_word_o <= entry_i.word;
        second_q <= !second_q;
      end
      if (entry_i.vfetch) vaddr_o <= entry_i.vaddr;
      if (entry_i.start)
      begin
        lat_o <= lat_q;
        starts_o <= starts_o + 1;
        {taken_q, second_q, cnt_q} <= '0;
      end
    end
  end
endmodule

// File: verification/tb_mcu_interrupt_controller.sv
// self-checking testbench of the interrupt controller
`timescale 1ns/1ps

module tb_mcu_interrupt_controller
  import mic_pkg::*;
;
  logic clock_i;
  logic rstn_i;
  logic cyc, stb, we, ack, return_from_exception, mask, done;
  logic [3:0] sel, cpu_wait;
  logic [7:0] adr, ccr_b, a_en, a_fl;
  logic [31:0] dat_w, dat_r;
  logic [4:0] pins;
  logic [7:0] wake;
  logic [22:0] ireq;
  logic [15:0] next_pc, rte_w, pc_word, ccr_word, vaddr;
  mic_entry_type entry;
  int lat, starts, err_count, check_count, i, e, w, b;

  // ====
  // design and cpu model
  mic_interrupt_controller u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .req_pins_i(pins), .wakeup_pins_i(wake),
    .internal_req_i(ireq), .instr_done_i(done), .next_pc_i(next_pc), .rte_i(return_from_exception),
    .rte_ccr_word_i(rte_w), .mask_o(mask), .entry_o(entry));
  mic_cpu_model u_cpu (.clock_i(clock_i), .rstn_i(rstn_i), .wait_i(cpu_wait), .entry_i(entry),
    .instr_done_o(done), .pc_word_o(pc_word), .ccr_word_o(ccr_word), .vaddr_o(vaddr),
    .lat_o(lat), .starts_o(starts));

  // clock and watchdog
  always #4 clock_i = ~clock_i;
  initial
  begin
    repeat (40000) @(posedge clock_i);
    err_count++;
    close_out();
  end

  // ====
  // comparison, bus and cpu helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic bus(input logic w_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clock_i);
    {cyc, stb, we, sel, adr, dat_w} <= {2'b11, w_en, 4'hf, a, d};
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    q = dat_r;
    if (n >= 40) chk("bus ack", 32'h1, 32'h0);
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask

  // clear the mask by a return with a random even byte; odd byte keeps bit 7 set
  task automatic unmask();
    ccr_b = 8'($urandom) & 8'h7f;
    @(posedge clock_i);
    return_from_exception <= 1'b1;
    rte_w <= {ccr_b, 8'($urandom) | 8'h80};
    next_pc <= {15'($urandom), 1'b0};
    @(posedge clock_i);
    return_from_exception <= 1'b0;
  endtask

  task automatic take(input int vec);
    int n0, n;
    n0 = starts;
    n = 0;
    cpu_wait <= 4'($urandom_range(12));
    while (starts == n0 && n < 300)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 300) chk("entry timeout", 32'h1, 32'h0);
    chk("vector address", 32'(vec << VEC_ADDR_SHIFT), {16'h0, vaddr});
    chk("stacked pc", {16'h0, next_pc}, {16'h0, pc_word});
    chk("stacked ccr", {16'h0, ccr_b, ccr_b}, {16'h0, ccr_word});
    chk("entry states", 32'd15, 32'(lat));
    chk("mask after entry", 32'h1, {31'h0, mask});
  endtask

  task automatic idle_check(input string what);
    int n0;
    n0 = starts;
    repeat (30) @(posedge clock_i);
    chk(what, 32'(n0), 32'(starts));
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ====
  // main sequence
  initial
  begin
    {clock_i, rstn_i, cyc, stb, we, return_from_exception, adr, dat_w, ireq, next_pc, rte_w} = '0;
    {sel, pins, wake, cpu_wait} = {4'hf, 5'h1f, 8'hff, 4'h0};
    void'($urandom(57));
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    chk("mask at reset", 32'h1, {31'h0, mask});
    rd(OFS_CCR, 32'h80, "ccr reset");
    rd(8'h3c, 32'h0, "unmapped read");
    rd(OFS_WAKE_EDGE, 32'h0, "wakeup edge reset");
    $display("test reset done");
    wr(OFS_PFR_ONE, 32'h1e);
    wr(OFS_PFR_THREE, 32'h1);
    for (i = 0; i < NUM_REQ_PINS; i++)
    begin
      e = $urandom_range(1);
      wr(OFS_EDGE_SEL, 32'(e) << i);
      wr(OFS_ENABLE_ONE, 32'h0);
      @(posedge clock_i) pins[i] <= 1'b0;
      rd(OFS_FLAGS_ONE, 32'(1 - e) << i, "pin flag after fall");
      @(posedge clock_i) pins[i] <= 1'b1;
      rd(OFS_FLAGS_ONE, 32'h1 << i, "pin flag after edge");
      unmask();
      idle_check("pin disabled");
      wr(OFS_ENABLE_ONE, 32'h1f);
      take(4 + i);
      wr(OFS_FLAGS_ONE, 32'hff);
      rd(OFS_FLAGS_ONE, 32'h1 << i, "flag kept");
      wr(OFS_FLAGS_ONE, 32'h0);
    end
    $display("test request pins done");
    wr(OFS_EDGE_SEL, 32'h0);
    @(posedge clock_i) pins <= 5'h15;
    idle_check("masked request");
    unmask();
    take(5);
    wr(OFS_FLAGS_ONE, 32'h08);
    unmask();
    take(7);
    wr(OFS_FLAGS_ONE, 32'h0);
    @(posedge clock_i) pins <= 5'h1f;
    $display("test priority done");
    w = $urandom_range(7);
    wr(OFS_PFR_FIVE, 32'hff);
    wr(OFS_ENABLE_ONE, 32'h0);
    @(posedge clock_i) wake[w] <= 1'b0;
    rd(OFS_WAKE_FLAGS, 32'h1 << w, "wakeup flag");
    unmask();
    idle_check("wakeup group off");
    wr(OFS_ENABLE_ONE, 32'h20);
    take(9);
    wr(OFS_WAKE_FLAGS, 32'h0);
    wr(OFS_WAKE_EDGE, 32'h1 << w);
    @(posedge clock_i) wake[w] <= 1'b1;
    rd(OFS_WAKE_FLAGS, 32'h1 << w, "wakeup rising flag");
    wr(OFS_WAKE_EDGE, 32'h0);
    wr(OFS_WAKE_FLAGS, 32'h0);
    $display("test wakeup done");
    wr(OFS_PFR_FIVE, 32'h0);
    @(posedge clock_i) wake[0] <= 1'b0;
    wr(OFS_PFR_FIVE, 32'h1);
    wr(OFS_WAKE_FLAGS, 32'h0);
    rd(OFS_WAKE_FLAGS, 32'h1, "spurious wakeup flag");
    wr(OFS_WAKE_FLAGS, 32'h0);
    rd(OFS_WAKE_FLAGS, 32'h0, "wakeup flag cleared");
    wr(OFS_PFR_ONE, 32'h0e);
    @(posedge clock_i) pins[4] <= 1'b0;
    wr(OFS_PFR_ONE, 32'h1e);
    wr(OFS_FLAGS_ONE, 32'h0);
    rd(OFS_FLAGS_ONE, 32'h10, "spurious pin flag");
    wr(OFS_FLAGS_ONE, 32'h0);
    @(posedge clock_i) {pins[4], wake[0]} <= 2'b11;
    $display("test pin switching done");
    for (i = 0; i < NUM_INT_SRC; i++)
    begin
      {a_en, a_fl, b} = (i < 2) ? {OFS_ENABLE_ONE, OFS_FLAGS_ONE, 32'(i + 6)} :
        (i < 10) ? {OFS_ENABLE_TWO, OFS_FLAGS_TWO, 32'(i - 2)} :
        {OFS_ENABLE_EXT, OFS_FLAGS_EXT, 32'(i - 10)};
      wr(a_en, 32'h0);
      @(posedge clock_i) ireq[i] <= 1'b1;
      @(posedge clock_i) ireq[i] <= 1'b0;
      rd(a_fl, 32'h0, "internal flag disabled");
      wr(a_en, 32'h1 << b);
      @(posedge clock_i) ireq[i] <= 1'b1;
      @(posedge clock_i) ireq[i] <= 1'b0;
      rd(a_fl, 32'h1 << b, "internal flag");
      unmask();
      take(VEC_INT_FIRST + i * (VEC_INT_LAST - VEC_INT_FIRST) / (NUM_INT_SRC - 1));
      wr(a_fl, 32'h0);
    end
    $display("test internal done");
    close_out();
  end
endmodule
